//--- hdl/eamd_regs.vh
// constants for the effective-address mode decoder
`ifndef EAMD_REGS_VH
`define EAMD_REGS_VH

// operand size encodings on opSize
`define EAMD_SZ_BYTE      2'h0
`define EAMD_SZ_WORD      2'h1
`define EAMD_SZ_LONG      2'h2

// mode field values
`define EAMD_MF_DREG      3'h0
`define EAMD_MF_AREG      3'h1
`define EAMD_MF_IND       3'h2
`define EAMD_MF_POSTINC   3'h3
`define EAMD_MF_PREDEC    3'h4
`define EAMD_MF_DISP16    3'h5
`define EAMD_MF_INDEX     3'h6
`define EAMD_MF_EXT       3'h7

// register field values under mode field 111
`define EAMD_RF_ABSW      3'h0
`define EAMD_RF_ABSL      3'h1
`define EAMD_RF_PCDISP    3'h2
`define EAMD_RF_PCINDEX   3'h3
`define EAMD_RF_IMM       3'h4

// twelve mode codes on srcModeCode and dstModeCode, 4'hf marks an illegal combination
`define EAMD_MC_DREG      4'h0
`define EAMD_MC_AREG      4'h1
`define EAMD_MC_IND       4'h2
`define EAMD_MC_POSTINC   4'h3
`define EAMD_MC_PREDEC    4'h4
`define EAMD_MC_DISP16    4'h5
`define EAMD_MC_INDEX     4'h6
`define EAMD_MC_PCDISP    4'h7
`define EAMD_MC_PCINDEX   4'h8
`define EAMD_MC_ABSW      4'h9
`define EAMD_MC_ABSL      4'ha
`define EAMD_MC_IMM       4'hb
`define EAMD_MC_BAD       4'hf

// brief extension word fields
`define EAMD_XW_IS_ADDR   15
`define EAMD_XW_REG_HI    14
`define EAMD_XW_REG_LO    12
`define EAMD_XW_SCALE_HI  10
`define EAMD_XW_SCALE_LO  9

// trap opcode: upper twelve bits, low four bits carry the vector
`define EAMD_TRAP_OPHI    12'h4e4
// multiply-accumulate opcode line
`define EAMD_MAC_LINE     4'ha
`define EAMD_MAC_COUNT    4'h9

`endif

//--- hdl/eamd_decoder.v
// effective-address mode decoder with big-endian operand lane placement
// Function
// RULE1: memory operands big-endian, MSB at lowest address
// RULE2: longword high half at N, low at N+2
// RULE3: word high byte at N, low at N+1
// RULE4: exactly twelve modes from mode and register
// RULE5: flag data, memory, control, alterable per mode
// RULE6: derive alterable-memory and data-alterable categories
// RULE7: mode 110 indexed, 8-bit displacement, all categories
// RULE8: 111/010 PC displacement, 111/011 PC index, unalterable
// RULE9: index any register, scaled by 1, 2, 4
// RULE10: immediate taken from words after operation word
// RULE11: displacement 16 bits plain, 8 bits indexed
// RULE12: trap carries 4-bit vector, sixteen vectors
// RULE13: reject decimal, bit-field, rotate, DBcc, 64-bit multiply
// RULE14: recognise nine multiply-accumulate ops, route them; code tells only eight apart, by opWord[8:6]
// RULE15: three operand sizes drive operand width
// RULE16: flags byte is status low byte only
// RULE17: modes 000-101 register direct and indirect forms
// RULE18: absolute short/long, immediate; unalterable, immediate non-control
// RULE19: address destination full width, word source sign-extended
`timescale 1ns/100ps
`include "eamd_regs.vh"

module eamd_decoder (
  input  wire        core_clk,       // core clock, 40 MHz
  input  wire        sys_rst,        // synchronous reset, active high
  input  wire        opValid,        // operation word and extension words valid
  input  wire [15:0] opWord,         // 16-bit operation word
  input  wire [15:0] extWord0,       // first extension word
  input  wire [15:0] extWord1,       // second extension word
  input  wire [1:0]  opSize,         // operand size code
  input  wire [31:0] indexValue,     // contents of the named index register
  input  wire [31:0] storeValue,     // operand to be written to memory
  input  wire [1:0]  memAddrLow,     // low bits of operand address N
  input  wire [31:0] memReadData,    // big-endian word read from memory
  input  wire        destIsAddrReg,  // load destination is an address register
  input  wire [15:0] status_word,    // current status word
  input  wire [7:0]  flagsIn,        // new condition flags byte
  output reg         decValid,       // decode results valid
  output reg  [3:0]  srcModeCode,    // source mode code
  output reg  [3:0]  dstModeCode,    // destination mode code
  output reg  [2:0]  srcRegNum,      // source register number
  output reg  [2:0]  dstRegNum,      // destination register number
  output reg  [3:0]  srcCats,        // source {data,memory,control,alterable}
  output reg  [3:0]  dstCats,        // destination {data,memory,control,alterable}
  output reg         srcAltMem,      // source is alterable memory
  output reg         srcDataAlt,     // source is data alterable
  output reg         dstAltMem,      // destination is alterable memory
  output reg         dstDataAlt,     // destination is data alterable
  output reg  [31:0] dispValue,      // sign-extended displacement
  output reg  [31:0] scaledIndex,    // index register value after scaling
  output reg  [2:0]  index_register, // index register number
  output reg         indexIsAddr,    // index register is an address register
  output reg         badScale,       // reserved scale factor code
  output reg  [31:0] immValue,       // immediate operand
  output reg         trapHit,        // trap instruction decoded
  output reg  [3:0]  trapVector,     // trap vector number
  output reg         macHit,         // route to multiply-accumulate unit
  output reg  [3:0]  macOpIndex,     // which of eight accumulate ops, from opWord[8:6]
  output reg         illegalInst,    // removed instruction or bad source mode
  output reg  [5:0]  operandWidth,   // operand width in bits
  output reg  [3:0]  laneEnable,     // byte lanes, lane 3 at address N+0
  output reg  [31:0] laneData,       // store data placed on byte lanes
  output reg  [31:0] loadValue,      // load operand, extended to 32 bits
  output reg  [15:0] statusOut       // status word after flags byte update
);

  // mode decode: {code[3:0], data, memory, control, alterable}
  // mode 111 reuses the register field as a sub-selector,
  // so three register codes under it stay illegal
  function [7:0] eaClass;
    input [2:0] mode;
    input [2:0] rnum;
    begin
      case (mode)
        `EAMD_MF_DREG:    eaClass = {`EAMD_MC_DREG,    4'h9}; // RULE17
        `EAMD_MF_AREG:    eaClass = {`EAMD_MC_AREG,    4'h1}; // RULE17
        `EAMD_MF_IND:     eaClass = {`EAMD_MC_IND,     4'hf}; // RULE17
        `EAMD_MF_POSTINC: eaClass = {`EAMD_MC_POSTINC, 4'hd}; // RULE17
        `EAMD_MF_PREDEC:  eaClass = {`EAMD_MC_PREDEC,  4'hd}; // RULE17
        `EAMD_MF_DISP16:  eaClass = {`EAMD_MC_DISP16,  4'hf}; // RULE17
        `EAMD_MF_INDEX:   eaClass = {`EAMD_MC_INDEX,   4'hf}; // RULE7
        default: begin
          case (rnum)
            `EAMD_RF_ABSW:    eaClass = {`EAMD_MC_ABSW,    4'he}; // RULE18
            `EAMD_RF_ABSL:    eaClass = {`EAMD_MC_ABSL,    4'he}; // RULE18
            `EAMD_RF_PCDISP:  eaClass = {`EAMD_MC_PCDISP,  4'he}; // RULE8
            `EAMD_RF_PCINDEX: eaClass = {`EAMD_MC_PCINDEX, 4'he}; // RULE8
            `EAMD_RF_IMM:     eaClass = {`EAMD_MC_IMM,     4'hc}; // RULE18
            default:          eaClass = {`EAMD_MC_BAD,     4'h0}; // RULE4
          endcase
        end
      endcase
    end
  endfunction

  // scale factor: 00 x1, 01 x2, 10 x4, 11 reserved
  // code 11 passes unscaled; badScale lets the address stage
  // raise its own fault instead of guessing a factor
  function [31:0] scaleIdx;
    input [31:0] val;
    input [1:0]  sf;
    begin
      case (sf)
        2'h0:    scaleIdx = val;                 // RULE9
        2'h1:    scaleIdx = {val[30:0], 1'b0};   // RULE9
        2'h2:    scaleIdx = {val[29:0], 2'h0};   // RULE9
        default: scaleIdx = val;
      endcase
    end
  endfunction

  // instructions removed from the base set
  // old code may still carry these; flagging them here lets the
  // core trap instead of misexecuting
  // limitation: only the encodings below are caught
  function removedOp;
    input [15:0] w;
    input [15:0] x;
    begin
      removedOp = 1'b0;
      // decimal add/subtract: 1100/1000 xxx1 0000 xxxx
      if ((w[15:12] == 4'hc || w[15:12] == 4'h8) && w[8:4] == 5'h10)
        removedOp = 1'b1;                                  // RULE13
      // bit-field group: 1110 1xxx 11xx xxxx
      if (w[15:11] == 5'h1d && w[7:6] == 2'h3)
        removedOp = 1'b1;                                  // RULE13
      // rotate register and memory forms
      if (w[15:12] == 4'he && w[7:6] != 2'h3 && w[4:3] == 2'h3)
        removedOp = 1'b1;                                  // RULE13
      if (w[15:9] == 7'h73 && w[7:6] == 2'h3)
        removedOp = 1'b1;                                  // RULE13
      // decrement and branch: 0101 cccc 1100 1xxx
      if (w[15:12] == 4'h5 && w[7:3] == 5'h19)
        removedOp = 1'b1;                                  // RULE13
      // long multiply with 64-bit result flagged in extension word
      if (w[15:6] == 10'h130 && x[10])
        removedOp = 1'b1;                                  // RULE13
    end
  endfunction

  // destination fields are swapped: register above mode
  wire [7:0]  srcCls = eaClass(opWord[5:3], opWord[2:0]);
  wire [7:0]  dstCls = eaClass(opWord[8:6], opWord[11:9]);
  reg  [15:0] dispWord;
  reg         useIndex;
  reg  [5:0]  widthNxt;
  reg  [3:0]  laneEnNxt;
  reg  [31:0] laneDataNxt;
  reg  [31:0] loadNxt;
  reg  [31:0] immNxt;
  wire [7:0]  laneByte [0:3];

  // extension word selection for displacements
  // only the source operand owns extension words here;
  // a destination displacement needs an upstream word counter
  always @* begin
    useIndex = (srcCls[7:4] == `EAMD_MC_INDEX) || (srcCls[7:4] == `EAMD_MC_PCINDEX);
    dispWord = extWord0;                                   // RULE11
  end

  // operand width and immediate fetch from trailing extension words
  // size code 11 runs as long so width and fetch never disagree
  always @* begin
    case (opSize)
      `EAMD_SZ_BYTE: begin
        widthNxt = 6'h08;                                  // RULE15
        immNxt   = {24'h000000, extWord0[7:0]};            // RULE10
      end
      `EAMD_SZ_WORD: begin
        widthNxt = 6'h10;                                  // RULE15
        immNxt   = {16'h0000, extWord0};                   // RULE10
      end
      default: begin
        widthNxt = 6'h20;                                  // RULE15
        immNxt   = {extWord0, extWord1};                   // RULE10
      end
    endcase
  end

  // byte lane k of the store word maps to address N+k, highest order first
  // on longword stores bit 31 heads for the lowest address
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : gLane
      assign laneByte[k] = storeValue[31 - 8 * k -: 8];    // RULE1
    end
  endgenerate

  // store placement; misaligned longwords are split by the load/store unit
  // narrow data is replicated so memory needs no shifter;
  // laneEnable alone decides which bytes land
  always @* begin
    laneEnNxt   = 4'h0;
    laneDataNxt = 32'h00000000;
    case (opSize)
      `EAMD_SZ_BYTE: begin
        laneEnNxt = 4'h8 >> memAddrLow;
        laneDataNxt = {4{laneByte[3]}};
      end
      `EAMD_SZ_WORD: begin
        laneEnNxt = memAddrLow[1] ? 4'h3 : 4'hc;
        laneDataNxt = {laneByte[2], laneByte[3], laneByte[2], laneByte[3]}; // RULE3
      end
      default: begin
        laneEnNxt = 4'hf;
        laneDataNxt = {storeValue[31:16], storeValue[15:0]}; // RULE2
      end
    endcase
  end

  // load extraction from big-endian lanes
  // byte loads never target an address register, so only
  // words are sign-extended; longwords fill it anyway
  always @* begin
    case (opSize)
      `EAMD_SZ_BYTE: begin
        case (memAddrLow)
          2'h0:    loadNxt = {24'h000000, memReadData[31:24]}; // RULE1
          2'h1:    loadNxt = {24'h000000, memReadData[23:16]};
          2'h2:    loadNxt = {24'h000000, memReadData[15:8]};
          default: loadNxt = {24'h000000, memReadData[7:0]};
        endcase
      end
      `EAMD_SZ_WORD: begin
        loadNxt = memAddrLow[1] ? {16'h0000, memReadData[15:0]}
                                : {16'h0000, memReadData[31:16]}; // RULE3
        if (destIsAddrReg)
          loadNxt = {{16{loadNxt[15]}}, loadNxt[15:0]};    // RULE19
      end
      default: loadNxt = {memReadData[31:16], memReadData[15:0]}; // RULE2
    endcase
  end

  // valid flag follows the request by one cycle
  // one-cycle pulse; other outputs hold for a slow consumer
  always @(posedge core_clk) begin
    if (sys_rst)
      decValid <= 1'b0;
    else
      decValid <= opValid;
  end

  // mode and category results
  // not qualified by opcode; consumers ignore unused fields
  always @(posedge core_clk) begin
    if (sys_rst) begin
      srcModeCode <= `EAMD_MC_BAD;
      dstModeCode <= `EAMD_MC_BAD;
      srcRegNum   <= 3'h0;
      dstRegNum   <= 3'h0;
      srcCats     <= 4'h0;
      dstCats     <= 4'h0;
      srcAltMem   <= 1'b0;
      srcDataAlt  <= 1'b0;
      dstAltMem   <= 1'b0;
      dstDataAlt  <= 1'b0;
    end else if (opValid) begin
      srcModeCode <= srcCls[7:4];                          // RULE4
      dstModeCode <= dstCls[7:4];                          // RULE4
      srcRegNum   <= opWord[2:0];
      dstRegNum   <= opWord[11:9];
      srcCats     <= srcCls[3:0];                          // RULE5
      dstCats     <= dstCls[3:0];                          // RULE5
      srcAltMem   <= srcCls[0] & srcCls[2];                // RULE6
      srcDataAlt  <= srcCls[0] & srcCls[3];                // RULE6
      dstAltMem   <= dstCls[0] & dstCls[2];                // RULE6
      dstDataAlt  <= dstCls[0] & dstCls[3];                // RULE6
    end
  end

  // displacement and index arithmetic for the source operand
  // indexed modes see only the low byte; the high byte
  // carries the index register and scale fields
  always @(posedge core_clk) begin
    if (sys_rst) begin
      dispValue      <= 32'h00000000;
      scaledIndex    <= 32'h00000000;
      index_register <= 3'h0;
      indexIsAddr    <= 1'b0;
      badScale       <= 1'b0;
    end else if (opValid) begin
      if (useIndex)
        dispValue <= {{24{dispWord[7]}}, dispWord[7:0]};   // RULE11
      else
        dispValue <= {{16{dispWord[15]}}, dispWord};       // RULE11
      scaledIndex    <= useIndex ? scaleIdx(indexValue,
                          extWord0[`EAMD_XW_SCALE_HI:`EAMD_XW_SCALE_LO]) : 32'h00000000; // RULE9
      index_register <= extWord0[`EAMD_XW_REG_HI:`EAMD_XW_REG_LO];  // RULE9
      indexIsAddr    <= extWord0[`EAMD_XW_IS_ADDR];                 // RULE9
      badScale       <= useIndex &&
                        (extWord0[`EAMD_XW_SCALE_HI:`EAMD_XW_SCALE_LO] == 2'h3);
    end
  end

  // instruction class results
  // vector captured always; only trapHit gives it meaning
  always @(posedge core_clk) begin
    if (sys_rst) begin
      trapHit     <= 1'b0;
      trapVector  <= 4'h0;
      macHit      <= 1'b0;
      macOpIndex  <= 4'h0;
      illegalInst <= 1'b0;
      immValue    <= 32'h00000000;
    end else if (opValid) begin
      trapHit     <= (opWord[15:4] == `EAMD_TRAP_OPHI);    // RULE12
      trapVector  <= opWord[3:0];                          // RULE12
      macHit      <= (opWord[15:12] == `EAMD_MAC_LINE) &&
                     ({1'b0, opWord[8:6]} < `EAMD_MAC_COUNT); // RULE14
      macOpIndex  <= {1'b0, opWord[8:6]};                  // RULE14
      illegalInst <= removedOp(opWord, extWord0) ||
                     (srcCls[7:4] == `EAMD_MC_BAD);        // RULE13
      immValue    <= immNxt;                               // RULE10
    end
  end

  // memory operand lanes and load value
  // width resets to longword, the natural bus width
  always @(posedge core_clk) begin
    if (sys_rst) begin
      operandWidth <= 6'h20;
      laneEnable   <= 4'h0;
      laneData     <= 32'h00000000;
      loadValue    <= 32'h00000000;
    end else if (opValid) begin
      operandWidth <= widthNxt;                            // RULE15
      laneEnable   <= laneEnNxt;                           // RULE1
      laneData     <= laneDataNxt;
      loadValue    <= loadNxt;                             // RULE19
    end
  end

  // flags byte write leaves the system byte untouched
  // the system byte is privileged and must never change here
  always @(posedge core_clk) begin
    if (sys_rst)
      statusOut <= 16'h0000;
    else if (opValid)
      statusOut <= {status_word[15:8], flagsIn};           // RULE16
  end

endmodule

//--- test/eamd_decoder_chk.sv
// port-level assertions for the effective-address decoder
`timescale 1ns/100ps
module eamd_decoder_chk (
  input wire        core_clk,      // core clock
  input wire        sys_rst,       // sync reset
  input wire        opValid,       // request strobe
  input wire [15:0] opWord,        // operation word
  input wire [1:0]  opSize,        // size code
  input wire [1:0]  memAddrLow,    // address low bits
  input wire [31:0] memReadData,   // memory word
  input wire        destIsAddrReg, // address destination
  input wire        decValid,      // result strobe
  input wire [3:0]  srcModeCode,   // source mode code
  input wire [3:0]  srcCats,       // source categories
  input wire        srcAltMem,     // alterable memory
  input wire        srcDataAlt,    // data alterable
  input wire        trapHit,       // trap seen
  input wire [3:0]  trapVector,    // trap vector
  input wire        macHit,        // accumulate op
  input wire [3:0]  macOpIndex,    // accumulate index
  input wire [5:0]  operandWidth,  // width in bits
  input wire [3:0]  laneEnable,    // byte lanes
  input wire [31:0] loadValue      // load result
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // half picked by address bit 1, lowest address in the top lanes
  wire [15:0] loadHalf = memAddrLow[1] ? memReadData[15:0] : memReadData[31:16];

  valid_echo_a: assert property (1'b1 |=> decValid == $past(opValid))
    else $error("result strobe does not follow request");
  hold_out_a: assert property (!opValid |=> $stable(srcModeCode))
    else $error("mode code moved without a request");
  cat_combo_a: assert property (decValid |-> srcAltMem == (srcCats[2] & srcCats[0])
    && srcDataAlt == (srcCats[3] & srcCats[0])) else $error("combined category wrong");
  index_mode_a: assert property (opValid && opWord[5:3] == 3'h6
    |=> srcModeCode == 4'h6 && srcCats == 4'hf) else $error("indexed mode decode wrong");
  pc_mode_a: assert property (opValid && opWord[5:1] == 5'h1d
    |=> srcCats == 4'he && srcModeCode == 4'h7 + $past(opWord[0])) else $error("pc mode wrong");
  trap_vec_a: assert property (opValid && opWord[15:4] == 12'h4e4
    |=> trapHit && trapVector == $past(opWord[3:0])) else $error("trap vector wrong");
  mac_route_a: assert property (opValid && opWord[15:12] == 4'ha
    |=> macHit && macOpIndex == {1'b0, $past(opWord[8:6])}) else $error("mac routing wrong");
  width_a: assert property (opValid |=> operandWidth == ($past(opSize) == 2'h0 ? 6'h08 :
    $past(opSize) == 2'h1 ? 6'h10 : 6'h20)) else $error("operand width wrong");
  word_lane_a: assert property (opValid && opSize == 2'h1
    |=> laneEnable == ($past(memAddrLow[1]) ? 4'h3 : 4'hc)) else $error("word lanes wrong");
  addr_ext_a: assert property (opValid && opSize == 2'h1 && destIsAddrReg
    |=> loadValue == {{16{$past(loadHalf[15])}}, $past(loadHalf)}) else $error("no sign extension");

  // main scenarios reached
  cover property (opValid && opWord[5:3] == 3'h6);
  cover property (opValid && opWord[15:4] == 12'h4e4);
  cover property (opValid && opSize == 2'h1 && destIsAddrReg);
endmodule

bind eamd_decoder eamd_decoder_chk uChk (
  .core_clk, .sys_rst, .opValid, .opWord, .opSize, .memAddrLow, .memReadData, .destIsAddrReg,
  .decValid, .srcModeCode, .srcCats, .srcAltMem, .srcDataAlt, .trapHit, .trapVector, .macHit,
  .macOpIndex, .operandWidth, .laneEnable, .loadValue
);

//--- test/eamd_mem_model.sv
// big-endian operand word seen by the load/store side
`timescale 1ns/100ps
module eamd_mem_model #(
  parameter [31:0] INIT = 32'h0f1e_2d3c  // contents loaded at reset
) (
  input  wire         core_clk,    // core clock
  input  wire         sys_rst,     // sync reset
  input  wire         decValid,    // decoder result strobe
  input  wire         doStore,     // request is a store
  input  wire [3:0]   laneEnable,  // lane 3 is address N+0
  input  wire [31:0]  laneData,    // lane data
  output logic [31:0] memReadData  // word, N+0 in the top byte
);
  // lanes written one by one so a wrong enable corrupts only its byte
  always @(posedge core_clk) begin
    if (sys_rst) begin
      memReadData <= INIT;
    end else if (decValid && doStore) begin
      for (int i = 0; i < 4; i++) begin
        if (laneEnable[i]) begin
          memReadData[8*i +: 8] <= laneData[8*i +: 8];
        end
      end
    end
  end
endmodule

//--- test/eamd_decoder_tb.sv
// self-checking bench for the effective-address decoder
`timescale 1ns/100ps
module eamd_decoder_tb;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        opValid = 1'b0;
  logic        destIsAddrReg = 1'b0;
  logic        doStore = 1'b0;
  logic [1:0]  opSize = 2'h2;
  logic [1:0]  memAddrLow = 2'h0;
  logic [7:0]  flagsIn = 8'hea;
  logic [15:0] opWord = 16'h0000;
  logic [15:0] extWord0 = 16'h0000;
  logic [15:0] extWord1 = 16'h0000;
  logic [15:0] status_word = 16'h2715;
  logic [31:0] indexValue = 32'h0000_1234;
  logic [31:0] storeValue = 32'h0000_0000;
  wire         decValid, indexIsAddr, badScale, trapHit, macHit, illegalInst;
  wire         srcAltMem, srcDataAlt, dstAltMem, dstDataAlt;
  wire [2:0]   srcRegNum, dstRegNum, index_register;
  wire [3:0]   srcModeCode, dstModeCode, srcCats, dstCats, trapVector, macOpIndex, laneEnable;
  wire [5:0]   operandWidth;
  wire [15:0]  statusOut;
  wire [31:0]  dispValue, scaledIndex, immValue, laneData, loadValue, memReadData;
  int          n_errors = 0;
  int          num_checks = 0;
  // rows: {mode, reg} field, expected mode code, expected categories
  logic [13:0] rows [0:12] = '{14'h0009, 14'h0811, 14'h102f, 14'h183d, 14'h204d, 14'h285f,
    14'h306f, 14'h389e, 14'h39ae, 14'h3a7e, 14'h3b8e, 14'h3cbc, 14'h3df0};
  logic [15:0] removed [0:4] = '{16'hc300, 16'h51c8, 16'he398, 16'h4c00, 16'he8c0};
  logic [5:0]  ea;

  eamd_decoder DUT (
    .core_clk, .sys_rst, .opValid, .opWord, .extWord0, .extWord1, .opSize, .indexValue,
    .storeValue, .memAddrLow, .memReadData, .destIsAddrReg, .status_word, .flagsIn,
    .decValid, .srcModeCode, .dstModeCode, .srcRegNum, .dstRegNum, .srcCats, .dstCats,
    .srcAltMem, .srcDataAlt, .dstAltMem, .dstDataAlt, .dispValue, .scaledIndex,
    .index_register, .indexIsAddr, .badScale, .immValue, .trapHit, .trapVector, .macHit,
    .macOpIndex, .illegalInst, .operandWidth, .laneEnable, .laneData, .loadValue, .statusOut
  );
  eamd_mem_model uMem (.core_clk, .sys_rst, .decValid, .doStore, .laneEnable, .laneData, .memReadData);

  always #12.5 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one request; results are promised one edge later, looked at on the next falling edge
  task automatic req(input logic [15:0] w, input logic [1:0] sz);
    @(negedge core_clk);
    opWord = w;
    opSize = sz;
    opValid = 1'b1;
    @(negedge core_clk);
    opValid = 1'b0;
    chk(decValid, 1'b1);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (4000) @(posedge core_clk);
    n_errors++;
    wrap_up;
  end

  initial begin
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    chk(decValid, 1'b0);
    chk(srcModeCode, 4'hf);
    chk(operandWidth, 6'h20);
    // every mode in both operand fields
    foreach (rows[i]) begin
      ea = rows[i][13:8];
      req({4'h2, ea[2:0], ea[5:3], ea}, 2'h2);
      chk(srcModeCode, rows[i][7:4]);
      chk(dstModeCode, rows[i][7:4]);
      chk(srcCats, rows[i][3:0]);
      chk(dstCats, rows[i][3:0]);
      chk(srcRegNum, ea[2:0]);
      chk(dstRegNum, ea[2:0]);
      chk(illegalInst, rows[i][7:4] == 4'hf);
      chk(srcAltMem, rows[i][0] & rows[i][2]);
      chk(srcDataAlt, rows[i][0] & rows[i][3]);
      chk(dstAltMem, rows[i][0] & rows[i][2]);
      chk(dstDataAlt, rows[i][0] & rows[i][3]);
      chk(trapHit, 1'b0);
      chk(macHit, 1'b0);
    end
    // indexed: register 5 as data and as address register, every scale code, negative 8-bit displacement
    for (int s = 0; s < 4; s++) begin
      extWord0 = {s[0], 3'h5, 1'b0, s[1:0], 9'h080};
      req(16'h0030, 2'h2);
      chk(scaledIndex, indexValue << (s == 3 ? 0 : s));
      chk(badScale, s == 3);
      chk(index_register, 3'h5);
      chk(indexIsAddr, s[0]);
      chk(dispValue, 32'hffff_ff80);
    end
    extWord0 = 16'h8001;
    req(16'h0028, 2'h2);
    chk(dispValue, 32'hffff_8001);
    // immediate at each size
    extWord0 = 16'h8123;
    extWord1 = 16'h4567;
    for (int z = 0; z < 4; z++) begin
      req(16'h003c, z[1:0]);
      chk(immValue, z == 0 ? 32'h0000_0023 : z == 1 ? 32'h0000_8123 : 32'h8123_4567);
      chk(operandWidth, 32'h0000_0008 << (z == 3 ? 2 : z));
    end
    // both ends of the trap vector range, every accumulate slot
    for (int v = 0; v < 16; v += 15) begin
      req({12'h4e4, v[3:0]}, 2'h2);
      chk(trapVector, v[3:0]);
      chk(trapHit, 1'b1);
    end
    for (int k = 0; k < 8; k++) begin
      req({4'ha, 3'h1, k[2:0], 6'h00}, 2'h2);
      chk(macOpIndex, k[3:0]);
      chk(macHit, 1'b1);
    end
    // removed instructions; bit 10 of the extension asks for a 64-bit product
    extWord0 = 16'h0400;
    foreach (removed[i]) begin
      req(removed[i], 2'h2);
      chk(illegalInst, 1'b1);
    end
    // stores at each size land in the model; the last is held one edge for the model
    doStore = 1'b1;
    storeValue = 32'h1122_3344;
    req(16'h2000, 2'h2);
    chk(laneEnable, 4'hf);
    chk(laneData, 32'h1122_3344);
    storeValue = 32'h0000_a5b6;
    memAddrLow = 2'h2;
    req(16'h2000, 2'h1);
    chk(laneData, 32'ha5b6_a5b6);
    storeValue = 32'h0000_0077;
    memAddrLow = 2'h1;
    req(16'h2000, 2'h0);
    chk(laneEnable, 4'h4);
    chk(laneData, 32'h7777_7777);
    @(negedge core_clk);
    doStore = 1'b0;
    memAddrLow = 2'h0;
    req(16'h2000, 2'h2);
    chk(loadValue, 32'h1177_a5b6);
    chk(statusOut, 16'h27ea);
    destIsAddrReg = 1'b1;
    memAddrLow = 2'h2;
    status_word = 16'hffff;
    flagsIn = 8'h00;
    req(16'h2000, 2'h1);
    chk(loadValue, 32'hffff_a5b6);
    chk(statusOut, 16'hff00);
    // byte load from lane N+1, then a zero-extended word from N+0
    destIsAddrReg = 1'b0;
    memAddrLow = 2'h1;
    req(16'h2000, 2'h0);
    chk(loadValue, 32'h0000_0077);
    memAddrLow = 2'h0;
    req(16'h2000, 2'h1);
    chk(loadValue, 32'h0000_1177);
    // reset in mid-run, then a request right after
    @(negedge core_clk);
    sys_rst = 1'b1;
    @(negedge core_clk);
    sys_rst = 1'b0;
    chk(srcCats, 4'h0);
    chk(decValid, 1'b0);
    req(16'h2030, 2'h2);
    chk(srcModeCode, 4'h6);
    wrap_up;
  end
endmodule
